/* File: rtl/status_pkg.sv */
// Purpose: constants for the servo status indicator logic
// Assumes: 200 MHz clock
// Notes:   display step counts are long and overridable at the top
package status_pkg;
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned PWRUP_MS         = 2000;
  localparam longint unsigned PWRUP_CYCLES =
    longint'(PWRUP_MS) * 1000 * CLK_MHZ;
  localparam int unsigned STEP_MS          = 500;
  localparam longint unsigned STEP_CYCLES  =
    longint'(STEP_MS) * 1000 * CLK_MHZ;
  localparam int unsigned CFG_W            = 8;
  localparam int unsigned ALARM_W          = 12;
  localparam logic [ALARM_W-1:0] BACKUP_ALARM_CODE = 12'h810;
  localparam logic [CFG_W-1:0]   CFG_RESET = 8'h00;
  localparam logic [2:0] CH_BLANK   = 3'h0;
  localparam logic [2:0] CH_FWD     = 3'h1;
  localparam logic [2:0] CH_REV     = 3'h2;
  localparam logic [2:0] CH_ALARM   = 3'h3;
  typedef enum logic [1:0] {SHOW_FWD, SHOW_REV, SHOW_ALARM} slot_e;
endpackage

/* File: rtl/servo_status_indicator.sv */
// Purpose: status lamps, scrolling code display, power-up alarm gating
// Assumes: status inputs are synchronous unless marked as pins
// Notes:   display holds each character for one step time
//
// Behaviour
// - alarm output held off two seconds after power-up
// - lamp one lit while motor rotates
// - lamp two lit while servo disabled
// - lamp three lit while command received
// - lamp four lit while link connected
// - forward code on limit inactive or overrun
// - reverse code on limit inactive or overrun
// - codes shown one character at a time
// - alarm code value identifies the error
// - backup alarm flagged until encoder setup
// - encoder cable removal clears stored position
// - depleted battery clears stored position
// - some configuration applies only after power cycle
`timescale 1ns/1ps
module servo_status_indicator
  import status_pkg::*;
#(
  parameter longint unsigned PWRUP_N = PWRUP_CYCLES,
  parameter longint unsigned STEP_N  = STEP_CYCLES
) (
  input  wire logic               clock,
  input  wire logic               rstn,
  input  wire logic               rotating,
  input  wire logic               servo_enabled,
  input  wire logic               command_active,
  input  wire logic               link_connected,
  input  wire logic               forward_limit_input,
  input  wire logic               reverse_limit_input,
  input  wire logic               fwd_soft_limit,
  input  wire logic               rev_soft_limit,
  input  wire logic               error_present,
  input  wire logic [ALARM_W-1:0] error_code,
  input  wire logic               abs_encoder,
  input  wire logic               encoder_cable_ok,
  input  wire logic               battery_ok,
  input  wire logic               encoder_setup,
  input  wire logic [CFG_W-1:0]   cfg_written,
  output logic [3:0]              status_lamp,
  output logic [2:0]              disp_char,
  output logic [ALARM_W-1:0]      disp_alarm,
  output logic                    alarm_output,
  output logic                    backup_alarm,
  output logic [CFG_W-1:0]        cfg_active
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  wire  [3:0] pin_raw = {forward_limit_input, reverse_limit_input,
                         encoder_cable_ok, battery_ok};
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pin_s1_r <= 4'hf;
      pin_s2_r <= 4'hf;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end
  wire fwd_pin_ok = pin_s2_r[3];
  wire rev_pin_ok = pin_s2_r[2];
  wire cable_ok   = pin_s2_r[1];
  wire batt_ok    = pin_s2_r[0];

  // ------------------------------------------------------------
  // power-up delay and configuration latch
  // ------------------------------------------------------------
  logic [63:0]      pwr_cnt_r;
  logic             pwr_done_r;
  logic [CFG_W-1:0] cfg_active_r;
  wire pwr_last = (pwr_cnt_r == PWRUP_N - 64'h1);
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pwr_cnt_r  <= 64'h0;
      pwr_done_r <= 1'b0;
    end else if (!pwr_done_r) begin
      pwr_cnt_r  <= pwr_cnt_r + 64'h1;
      pwr_done_r <= pwr_last;
    end
  end
  // configuration taken once, at the first edge after reset release
  logic cfg_taken_r;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cfg_taken_r  <= 1'b0;
      cfg_active_r <= CFG_RESET;
    end else if (!cfg_taken_r) begin
      cfg_taken_r  <= 1'b1;
      cfg_active_r <= cfg_written;
    end
  end
  assign cfg_active = cfg_active_r;

  // ------------------------------------------------------------
  // encoder backup alarm
  // ------------------------------------------------------------
  logic pos_valid_r;
  wire  pos_lost = !cable_ok || !batt_ok;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pos_valid_r <= 1'b0;
    end else if (pos_lost) begin
      pos_valid_r <= 1'b0;
    end else if (encoder_setup) begin
      pos_valid_r <= 1'b1;
    end
  end
  wire backup_err = abs_encoder && !pos_valid_r;
  assign backup_alarm = backup_err;

  // ------------------------------------------------------------
  // alarm selection and output
  // ------------------------------------------------------------
  wire              any_alarm  = error_present || backup_err;
  wire [ALARM_W-1:0] alarm_sel = error_present ? error_code
                                              : BACKUP_ALARM_CODE;
  logic alarm_out_r;
  always_ff @(posedge clock) begin
    if (!rstn) alarm_out_r <= 1'b0;
    else       alarm_out_r <= pwr_done_r && any_alarm;
  end
  assign alarm_output = alarm_out_r;

  // ------------------------------------------------------------
  // status lamps
  // ------------------------------------------------------------
  logic [3:0] lamp_r;
  wire  [3:0] lamp_nxt = {link_connected, command_active,
                          !servo_enabled, rotating};
  always_ff @(posedge clock) begin
    if (!rstn) lamp_r <= 4'h2;
    else       lamp_r <= lamp_nxt;
  end
  assign status_lamp = lamp_r;

  // ------------------------------------------------------------
  // scrolling code display
  // ------------------------------------------------------------
  wire fwd_code = !fwd_pin_ok || fwd_soft_limit;
  wire rev_code = !rev_pin_ok || rev_soft_limit;
  wire [2:0] active = {any_alarm, rev_code, fwd_code};

  logic [63:0]        step_cnt_r;
  logic               blank_r;
  slot_e              slot_r;
  logic [2:0]         char_r;
  logic [ALARM_W-1:0] alm_r;
  wire step_end = (step_cnt_r == STEP_N - 64'h1);

  // next active slot after the current one, wrapping around
  slot_e slot_nxt;
  always_comb begin
    slot_nxt = slot_r;
    case (slot_r)
      SHOW_FWD:   slot_nxt = active[1] ? SHOW_REV
                           : active[2] ? SHOW_ALARM : SHOW_FWD;
      SHOW_REV:   slot_nxt = active[2] ? SHOW_ALARM
                           : active[0] ? SHOW_FWD : SHOW_REV;
      SHOW_ALARM: slot_nxt = active[0] ? SHOW_FWD
                           : active[1] ? SHOW_REV : SHOW_ALARM;
      default:    slot_nxt = SHOW_FWD;
    endcase
  end
  wire [2:0] char_nxt = (slot_nxt == SHOW_FWD) ? CH_FWD :
                        (slot_nxt == SHOW_REV) ? CH_REV : CH_ALARM;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      step_cnt_r <= 64'h0;
      blank_r    <= 1'b1;
      slot_r     <= SHOW_ALARM;
      char_r     <= CH_BLANK;
      alm_r      <= '0;
    end else if (step_end) begin
      step_cnt_r <= 64'h0;
      if (!blank_r || active == 3'h0) begin
        blank_r <= 1'b1;
        char_r  <= CH_BLANK;
      end else begin
        blank_r <= 1'b0;
        slot_r  <= slot_nxt;
        char_r  <= char_nxt;
        alm_r   <= alarm_sel;
      end
    end else begin
      step_cnt_r <= step_cnt_r + 64'h1;
    end
  end
  assign disp_char  = char_r;
  assign disp_alarm = alm_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_pwr_quiet;
    @(posedge clock) disable iff (!rstn)
      !pwr_done_r |-> ##1 !alarm_output;
  endproperty
  a_pwr_quiet: assert property (p_pwr_quiet)
    else $error("alarm output active during power-up");

  property p_lamps;
    @(posedge clock) disable iff (!rstn)
      rstn |=> status_lamp == {$past(link_connected),
        $past(command_active), !$past(servo_enabled), $past(rotating)};
  endproperty
  a_lamps: assert property (p_lamps)
    else $error("status lamps do not follow state");

  property p_blank_between;
    @(posedge clock) disable iff (!rstn)
      (step_end && !blank_r) |=> disp_char == CH_BLANK;
  endproperty
  a_blank_between: assert property (p_blank_between)
    else $error("no blank step after a character");

  property p_backup_hold;
    @(posedge clock) disable iff (!rstn)
      (abs_encoder && pos_lost) |=> backup_alarm || !abs_encoder;
  endproperty
  a_backup_hold: assert property (p_backup_hold)
    else $error("backup alarm missing after position loss");

  property p_alarm_follow;
    @(posedge clock) disable iff (!rstn)
      (pwr_done_r && any_alarm) |=> alarm_output;
  endproperty
  a_alarm_follow: assert property (p_alarm_follow)
    else $error("alarm output not raised for alarm");

  property p_cfg_stable;
    @(posedge clock) disable iff (!rstn)
      cfg_taken_r |=> $stable(cfg_active);
  endproperty
  a_cfg_stable: assert property (p_cfg_stable)
    else $error("configuration changed without power cycle");

  property p_fwd_shown;
    @(posedge clock) disable iff (!rstn)
      (step_end && blank_r && slot_nxt == SHOW_FWD && active != 3'h0)
        |=> disp_char == CH_FWD && $past(fwd_code);
  endproperty
  a_fwd_shown: assert property (p_fwd_shown)
    else $error("forward code shown wrongly");

  property p_one_char;
    @(posedge clock) disable iff (!rstn)
      !step_end |=> $stable(disp_char);
  endproperty
  a_one_char: assert property (p_one_char)
    else $error("display changed mid step");

  property p_rev_shown;
    @(posedge clock) disable iff (!rstn)
      (step_end && blank_r && slot_nxt == SHOW_REV && active != 3'h0)
        |=> disp_char == CH_REV && $past(rev_code);
  endproperty
  a_rev_shown: assert property (p_rev_shown)
    else $error("reverse code shown wrongly");

  property p_alarm_shown;
    @(posedge clock) disable iff (!rstn)
      (step_end && blank_r && slot_nxt == SHOW_ALARM && active != 3'h0)
        |=> disp_char == CH_ALARM && disp_alarm == $past(alarm_sel)
            && $past(any_alarm);
  endproperty
  a_alarm_shown: assert property (p_alarm_shown)
    else $error("alarm code shown wrongly");

  property p_idle_blank;
    @(posedge clock) disable iff (!rstn)
      (step_end && active == 3'h0) |=> disp_char == CH_BLANK;
  endproperty
  a_idle_blank: assert property (p_idle_blank)
    else $error("display not blank with no active code");

  property p_alarm_clear;
    @(posedge clock) disable iff (!rstn)
      !any_alarm |=> !alarm_output;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear)
    else $error("alarm output raised with no alarm");

  property p_pwr_early;
    @(posedge clock) disable iff (!rstn)
      (!pwr_done_r && !pwr_last) |=> !pwr_done_r;
  endproperty
  a_pwr_early: assert property (p_pwr_early)
    else $error("power-up delay ended early");

  property p_setup_clears;
    @(posedge clock) disable iff (!rstn)
      (encoder_setup && !pos_lost) |=> !backup_alarm;
  endproperty
  a_setup_clears: assert property (p_setup_clears)
    else $error("encoder setup did not clear backup alarm");

  property p_backup_keep;
    @(posedge clock) disable iff (!rstn)
      (backup_alarm && !encoder_setup) |=> backup_alarm || !abs_encoder;
  endproperty
  a_backup_keep: assert property (p_backup_keep)
    else $error("backup alarm cleared without setup");

  property p_cfg_take;
    @(posedge clock) disable iff (!rstn)
      (rstn && !cfg_taken_r) |=> cfg_active == $past(cfg_written);
  endproperty
  a_cfg_take: assert property (p_cfg_take)
    else $error("configuration not taken after reset");

endmodule

/* File: testbench/host_panel_model.sv */
// Purpose: host and operator side beside the status logic
// Assumes: PN matches the power-up count given to the design
// Notes:   setup request only while auto_setup is high
`timescale 1ns/1ps
module host_panel_model
  import status_pkg::*;
#(
  parameter longint unsigned PN = 20
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic alarm_output,
  input  wire logic backup_alarm,
  input  wire logic auto_setup,
  output logic      alarm_seen,
  output logic      encoder_setup
);
  longint unsigned cnt;
  always_ff @(posedge clock) begin
    cnt           <= rstn ? cnt + 1 : 0;
    alarm_seen    <= rstn && cnt > PN + 1 && alarm_output;
    encoder_setup <= auto_setup && backup_alarm;
  end
endmodule

/* File: testbench/servo_status_indicator_logic_bench.sv */
// Purpose: self-checking bench for the status indicator logic
// Assumes: shortened power-up and step counts
// Notes:   inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ps
module servo_status_indicator_logic_bench;
  import status_pkg::*;
  localparam longint unsigned PN = 20;
  localparam longint unsigned SN = 4;
  logic clock = 0, rstn = 0, rotating = 0, servo_enabled = 0;
  logic command_active = 0, link_connected = 0, fwd_soft_limit = 0;
  logic forward_limit_input = 1, reverse_limit_input = 1;
  logic rev_soft_limit = 0, error_present = 1, abs_encoder = 0;
  logic encoder_cable_ok = 1, battery_ok = 1, auto_setup = 0;
  logic [ALARM_W-1:0] error_code = 12'he60, exp_alm;
  logic [CFG_W-1:0]   cfg_written = 8'h00, cfg_active;
  logic [3:0]         status_lamp;
  logic [2:0]         disp_char;
  logic [ALARM_W-1:0] disp_alarm;
  logic alarm_output, backup_alarm, alarm_seen, encoder_setup, hit;
  int   errors = 0, checks = 0;
  servo_status_indicator #(.PWRUP_N(PN), .STEP_N(SN))
    servo_status_indicator_inst (.clock, .rstn, .rotating,
    .servo_enabled, .command_active, .link_connected,
    .forward_limit_input, .reverse_limit_input, .fwd_soft_limit,
    .rev_soft_limit, .error_present, .error_code, .abs_encoder,
    .encoder_cable_ok, .battery_ok, .encoder_setup, .cfg_written,
    .status_lamp, .disp_char, .disp_alarm, .alarm_output,
    .backup_alarm, .cfg_active);
  host_panel_model #(.PN(PN)) host_panel_model_inst (.clock, .rstn,
    .alarm_output, .backup_alarm, .auto_setup, .alarm_seen,
    .encoder_setup);
  initial begin
    forever #2.5 clock = ~clock;
  end
  task automatic chk(input string n, input logic [11:0] s, e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // watch the display for char c, checking blanks and alarm values
  task automatic scan(input logic [2:0] c);
    logic [2:0] prev;
    prev = disp_char;
    hit  = 0;
    for (int i = 0; i < 12 * SN; i++) begin
      cyc(1);
      if (disp_char === c) hit = 1;
      if (prev !== CH_BLANK && disp_char !== prev)
        chk("gap", disp_char, CH_BLANK);
      if (disp_char === CH_ALARM)
        chk("alarm code", disp_alarm, exp_alm);
      prev = disp_char;
    end
    chk("char seen", hit, 1'b1);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    exp_alm = 12'he60;
    cyc(3);
    chk("lamps rst", status_lamp, 4'h2);
    @(posedge clock) rstn <= 1;
    cyc(PN / 2);
    chk("alarm early", alarm_output, 1'b0);
    chk("host early", alarm_seen, 1'b0);
    cyc(PN);
    chk("alarm late", alarm_output, 1'b1);
    chk("host late", alarm_seen, 1'b1);
    $display("test power-up done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clock) {link_connected, command_active, servo_enabled,
        rotating} <= 4'h1 << i;
      cyc(2);
      chk("lamps", status_lamp, (4'h1 << i) ^ 4'h2);
    end
    $display("test lamps done");
    scan(CH_ALARM);
    @(posedge clock) forward_limit_input <= 0;
    scan(CH_FWD);
    @(posedge clock) begin
      forward_limit_input <= 1;
      fwd_soft_limit      <= 1;
      reverse_limit_input <= 0;
    end
    scan(CH_FWD);
    scan(CH_REV);
    @(posedge clock) begin
      reverse_limit_input <= 1;
      rev_soft_limit      <= 1;
    end
    scan(CH_REV);
    $display("test display done");
    @(posedge clock) begin
      fwd_soft_limit <= 0;
      rev_soft_limit <= 0;
      error_present  <= 0;
      abs_encoder    <= 1;
    end
    exp_alm = BACKUP_ALARM_CODE;
    cyc(3);
    chk("backup", backup_alarm, 1'b1);
    scan(CH_ALARM);
    @(posedge clock) auto_setup <= 1;
    cyc(4);
    chk("backup set", backup_alarm, 1'b0);
    chk("alarm clear", alarm_output, 1'b0);
    @(posedge clock) battery_ok <= 0;
    cyc(6);
    chk("battery", backup_alarm, 1'b1);
    @(posedge clock) battery_ok <= 1;
    cyc(6);
    chk("battery set", backup_alarm, 1'b0);
    @(posedge clock) encoder_cable_ok <= 0;
    cyc(6);
    chk("cable", backup_alarm, 1'b1);
    @(posedge clock) encoder_cable_ok <= 1;
    cyc(6);
    chk("cable set", backup_alarm, 1'b0);
    $display("test encoder done");
    @(posedge clock) cfg_written <= 8'h5a;
    cyc(3);
    chk("cfg held", cfg_active, 8'h00);
    @(posedge clock) rstn <= 0;
    cyc(2);
    @(posedge clock) rstn <= 1;
    cyc(3);
    chk("cfg cycled", cfg_active, 8'h5a);
    $display("test config done");
    final_report();
  end
  initial begin
    #15000;
    errors++;
    final_report();
  end
endmodule
